// ===== design/rtc_core.sv
// real-time counter core: axi4-lite registers, sync handshake, events and trim
`timescale 1ns/1ps

// Summary of operation
// - counting and flags continue during sleep while the prescaler tick runs
// - interrupt line may wake the system; events reach logic without waking it
// - sync_in_progress rises on a synchronised access and falls when it completes
// - sync_done_flag is set when a synchronised operation completes
// - a synchronised access during sync_in_progress stalls the bus until accepted
// - soft reset and enable writes take effect only after the sync handshake
// - count, match0, trim and control writes are all write-synchronised
// - count reads are synchronised before data returns to the bus
// - prescaler bits 2 to 9 give periodic events when enabled
// - periodic event n fires every 2 to the n+3 prescaler ticks
// - no periodic events when the prescaler division setting is zero
// - trim inserts or skips one prescaler count at most once per 4096 ticks
// - trim magnitude sets how many of 240 windows get an adjustment
// - sign clear inserts counts, sign set skips counts
// - inserted or skipped counts also shift periodic events
// - register decode follows the operating mode field
// - counter increments per count_tick, wraps to zero and sets wrap_flag
// - equality with match0_value sets match0_flag on the next count_tick
// - clear_on_match zeroes the counter after a hit, raising both flags
// - enable set and clear registers gate flags onto the request line
module rtc_core #(
   parameter int unsigned WIN_CYCLES  = rtc_pkg::WIN_CYCLES,  // ticks per trim window
   parameter int unsigned WIN_GROUP   = rtc_pkg::WIN_GROUP,   // windows per trim group
   parameter int unsigned SYNC_CYCLES = rtc_pkg::SYNC_CYCLES  // handshake length
) (
   input  wire logic               i_clock,          // 100 MHz clock
   input  wire logic               i_rst_n,          // async reset, active low
   input  wire logic               i_prescaler_tick, // one prescaler clock edge
   input  wire logic               i_debug_halt,     // cpu halted by debugger
   input  wire logic [7:0]         i_s_awaddr,       // write address
   input  wire logic               i_s_awvalid,      // write address valid
   output logic                    o_s_awready,      // write address ready
   input  wire logic [31:0]        i_s_wdata,        // write data
   input  wire logic [3:0]         i_s_wstrb,        // write byte strobes
   input  wire logic               i_s_wvalid,       // write data valid
   output logic                    o_s_wready,       // write data ready
   output logic [1:0]              o_s_bresp,        // write response
   output logic                    o_s_bvalid,       // write response valid
   input  wire logic               i_s_bready,       // write response ready
   input  wire logic [7:0]         i_s_araddr,       // read address
   input  wire logic               i_s_arvalid,      // read address valid
   output logic                    o_s_arready,      // read address ready
   output logic [31:0]             o_s_rdata,        // read data
   output logic [1:0]              o_s_rresp,        // read response
   output logic                    o_s_rvalid,       // read data valid
   input  wire logic               i_s_rready,       // read data ready
   output logic                    o_irq,            // combined interrupt request
   output rtc_pkg::rtc_event_t     o_event           // event pulses
);
   localparam int WW = $clog2(WIN_CYCLES);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   logic                        aw_full_q, awrdy_q, w_full_q, wrdy_q, bvalid_q;
   logic [1:0]                  bresp_q, rresp_q;
   logic [7:0]                  awaddr_q, araddr_q;
   logic [31:0]                 wdata_q, rdata_q;
   logic [3:0]                  wstrb_q;
   logic                        ar_full_q, arrdy_q, rvalid_q, rd_wait_q;
   logic [3:0]                  sync_cnt_q;
   logic                        sync_rd_q;
   logic [7:0]                  pend_idx_q;
   logic [31:0]                 pend_data_q;
   logic [15:0]                 ctrl_q, ctrl_d, read_request_strobe_q, read_request_strobe_d, event_output_control_q, event_output_control_d;
   logic [7:0]                  inten_q, inten_d, flags_q, flags_d, dbg_q, dbg_d;
   logic [7:0]                  trim_q, trim_d;
   logic [31:0]                 cnt_q, cnt_d, cmp_q, cmp_d;
   logic [rtc_pkg::PSC_W-1:0]   psc_q, psc_d;
   logic [WW-1:0]               win_q;
   logic [7:0]                  grp_q;
   logic                        irq_q;
   rtc_pkg::rtc_event_t         evt_q;
   logic [31:0]                 wr_cur, rd_val;

   ////////////////////////////////////////////////////////////////////////////////
   // address decode, mode dependent
   function automatic logic is_mapped(input logic [7:0] idx, input logic m0);
      case (idx)
         rtc_pkg::IDX_CTRL, rtc_pkg::IDX_READ_REQUEST_STROBE, rtc_pkg::IDX_EVENT_OUTPUT_CONTROL,
         rtc_pkg::IDX_ENCLR, rtc_pkg::IDX_ENSET, rtc_pkg::IDX_FLAGS,
         rtc_pkg::IDX_STATUS, rtc_pkg::IDX_DBG, rtc_pkg::IDX_TRIM: return 1'b1;
         rtc_pkg::IDX_COUNT, rtc_pkg::IDX_MATCH0: return m0;
         default: return 1'b0;
      endcase
   endfunction : is_mapped

   // registers whose writes pass the handshake
   function automatic logic wr_synced(input logic [7:0] idx);
      return (idx == rtc_pkg::IDX_CTRL) || (idx == rtc_pkg::IDX_COUNT) ||
             (idx == rtc_pkg::IDX_MATCH0) || (idx == rtc_pkg::IDX_TRIM);
   endfunction : wr_synced

   wire        mode0    = ctrl_q[rtc_pkg::CTRL_MODE_LO +: 2] == rtc_pkg::MODE_COUNT32;
   wire [7:0]  w_idx    = {2'h0, awaddr_q[7:2]};
   wire [7:0]  r_idx    = {2'h0, araddr_q[7:2]};
   wire        w_map    = is_mapped(w_idx, mode0);
   wire        r_map    = is_mapped(r_idx, mode0);
   wire        w_sync   = w_map & wr_synced(w_idx);
   wire        r_sync   = r_map & (r_idx == rtc_pkg::IDX_COUNT);
   wire        busy     = sync_cnt_q != 4'h0;
   wire        sync_done = sync_cnt_q == 4'h1;
   wire [31:0] wmask    = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire [31:0] wbits    = wdata_q & wmask;
   wire [31:0] merged   = (wr_cur & ~wmask) | wbits;

   // access launch, synchronised accesses stalled while the handshake is busy
   wire wr_go      = aw_full_q & w_full_q & ~bvalid_q & ~sync_done & ~(w_sync & busy);
   wire rd_go      = ar_full_q & ~rvalid_q & ~rd_wait_q & ~wr_go & ~(r_sync & busy);
   wire sync_start = (wr_go & w_sync) | (rd_go & r_sync);
   wire apply_now  = wr_go & w_map & ~w_sync;
   wire apply_sync = sync_done & ~sync_rd_q;
   wire sw_reset   = apply_sync & (pend_idx_q == rtc_pkg::IDX_CTRL) &
                     pend_data_q[rtc_pkg::CTRL_SOFT_RESET_BIT];

   // register view for reads and byte merging
   function automatic logic [31:0] reg_view(input logic [7:0] idx);
      case (idx)
         rtc_pkg::IDX_CTRL:   return {16'h0, ctrl_q};
         rtc_pkg::IDX_READ_REQUEST_STROBE:   return {16'h0, read_request_strobe_q};
         rtc_pkg::IDX_EVENT_OUTPUT_CONTROL: return {16'h0, event_output_control_q};
         rtc_pkg::IDX_ENCLR,
         rtc_pkg::IDX_ENSET:  return {24'h0, inten_q};
         rtc_pkg::IDX_FLAGS:  return {24'h0, flags_q};
         rtc_pkg::IDX_STATUS: return 32'(busy) << rtc_pkg::STAT_BUSY;
         rtc_pkg::IDX_DBG:    return {24'h0, dbg_q};
         rtc_pkg::IDX_TRIM:   return {24'h0, trim_q};
         rtc_pkg::IDX_COUNT:  return cnt_q;
         rtc_pkg::IDX_MATCH0: return cmp_q;
         default:             return 32'h0;
      endcase
   endfunction : reg_view

   always_comb begin
      wr_cur = reg_view(w_idx);
      rd_val = r_map ? reg_view(r_idx) : 32'h0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // prescaler, trim and tick generation, independent of sleep
   wire       run      = ctrl_q[rtc_pkg::CTRL_EN] & (~i_debug_halt | dbg_q[rtc_pkg::DBG_RUN]);
   wire       pre_adv  = run & i_prescaler_tick;
   wire       win_end  = win_q == WW'(WIN_CYCLES - 1);
   wire       grp_end  = grp_q == 8'(WIN_GROUP - 1);
   wire       corr     = pre_adv & win_end & (grp_q < {1'b0, trim_q[6:0]});
   wire       skip     = trim_q[rtc_pkg::TRIM_SIGN];
   wire [rtc_pkg::PSC_W-1:0] step = corr ? (skip ? 10'h002 : 10'h000) : 10'h001;
   wire [3:0] psel     = ctrl_q[rtc_pkg::CTRL_PSC_LO +: 4];
   wire [3:0] psel_bit = (psel > 4'ha) ? 4'h9 : psel - 4'h1;
   wire [rtc_pkg::PSC_W-1:0] rise = ~psc_q & psc_d & {rtc_pkg::PSC_W{pre_adv}};
   wire       tick     = (psel == 4'h0) ? pre_adv : rise[psel_bit];

   assign psc_d = pre_adv ? psc_q + step : psc_q;

   // periodic events from prescaler bits 2..9
   logic [7:0] per_evt;
   for (genvar n = 0; n < 8; n++) begin : g_per
      assign per_evt[n] = rise[n + rtc_pkg::PER_BASE] & (psel != 4'h0);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // counter and flag sources
   wire hit     = cnt_q == cmp_q;
   wire mclr    = ctrl_q[rtc_pkg::CTRL_MCLR];
   wire set_cmp = tick & hit;
   wire set_wrp = tick & ((cnt_q == rtc_pkg::CNT_TOP) | (hit & mclr));
   wire [7:0] set_v = (8'(set_cmp) << rtc_pkg::FLG_MATCH0) |
                      (8'(set_wrp) << rtc_pkg::FLG_WRAP) |
                      (8'(sync_done) << rtc_pkg::FLG_SYNC);
   wire [7:0] clr_v = (apply_now && w_idx == rtc_pkg::IDX_FLAGS) ?
                      wbits[7:0] & rtc_pkg::IRQ_MASK : 8'h0;
   wire ap_ctrl  = apply_sync & (pend_idx_q == rtc_pkg::IDX_CTRL);
   wire ap_cnt   = apply_sync & (pend_idx_q == rtc_pkg::IDX_COUNT);
   wire ap_cmp   = apply_sync & (pend_idx_q == rtc_pkg::IDX_MATCH0);
   wire ap_trim  = apply_sync & (pend_idx_q == rtc_pkg::IDX_TRIM);

   // next values of software visible registers
   always_comb begin
      ctrl_d   = ap_ctrl ? pend_data_q[15:0] & rtc_pkg::CTRL_WMASK : ctrl_q;
      read_request_strobe_d   = (apply_now && w_idx == rtc_pkg::IDX_READ_REQUEST_STROBE) ?
                 merged[15:0] & rtc_pkg::READ_REQUEST_STROBE_WMASK : read_request_strobe_q;
      event_output_control_d = (apply_now && w_idx == rtc_pkg::IDX_EVENT_OUTPUT_CONTROL) ?
                 merged[15:0] & rtc_pkg::EVENT_OUTPUT_CONTROL_WMASK : event_output_control_q;
      inten_d  = inten_q;
      if (apply_now && w_idx == rtc_pkg::IDX_ENSET)
         inten_d = inten_q | (wbits[7:0] & rtc_pkg::IRQ_MASK);
      if (apply_now && w_idx == rtc_pkg::IDX_ENCLR)
         inten_d = inten_q & ~(wbits[7:0] & rtc_pkg::IRQ_MASK);
      flags_d  = (flags_q & ~clr_v) | set_v;
      dbg_d    = (apply_now && w_idx == rtc_pkg::IDX_DBG) ?
                 merged[7:0] & rtc_pkg::DBG_WMASK : dbg_q;
      trim_d   = ap_trim ? pend_data_q[7:0] : trim_q;
      cmp_d    = ap_cmp ? pend_data_q : cmp_q;
      if (ap_cnt)
         cnt_d = pend_data_q;
      else if (set_cmp && mclr)
         cnt_d = 32'h0;
      else if (tick)
         cnt_d = cnt_q + 32'h1;
      else
         cnt_d = cnt_q;
      if (sw_reset) begin
         ctrl_d   = 16'h0;
         read_request_strobe_d   = 16'h0;
         event_output_control_d = 16'h0;
         inten_d  = 8'h0;
         flags_d  = set_v & (8'h1 << rtc_pkg::FLG_SYNC);
         trim_d   = 8'h0;
         cmp_d    = 32'h0;
         cnt_d    = 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file and time base
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl_q   <= 16'h0;
         read_request_strobe_q   <= 16'h0;
         event_output_control_q <= 16'h0;
         inten_q  <= 8'h0;
         flags_q  <= 8'h0;
         dbg_q    <= 8'h0;
         trim_q   <= 8'h0;
         cnt_q    <= 32'h0;
         cmp_q    <= 32'h0;
      end else begin
         ctrl_q   <= ctrl_d;
         read_request_strobe_q   <= read_request_strobe_d;
         event_output_control_q <= event_output_control_d;
         inten_q  <= inten_d;
         flags_q  <= flags_d;
         dbg_q    <= dbg_d;
         trim_q   <= trim_d;
         cnt_q    <= cnt_d;
         cmp_q    <= cmp_d;
      end
   end

   // prescaler and trim windows
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         psc_q <= '0;
         win_q <= '0;
         grp_q <= 8'h0;
      end else if (sw_reset) begin
         psc_q <= '0;
         win_q <= '0;
         grp_q <= 8'h0;
      end else if (pre_adv) begin
         psc_q <= psc_d;
         win_q <= win_end ? '0 : win_q + WW'(1);
         if (win_end)
            grp_q <= grp_end ? 8'h0 : grp_q + 8'h1;
      end
   end

   // event and interrupt outputs, level request may wake the system
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         evt_q <= '0;
         irq_q <= 1'b0;
      end else begin
         evt_q.periodic <= per_evt & event_output_control_q[7:0];
         evt_q.wrap     <= set_wrp & event_output_control_q[rtc_pkg::EV_WRAP];
         evt_q.match0   <= set_cmp & event_output_control_q[rtc_pkg::EV_MATCH0];
         irq_q          <= |(flags_q & inten_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // sync handshake engine
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync_cnt_q  <= 4'h0;
         sync_rd_q   <= 1'b0;
         pend_idx_q  <= 8'h0;
         pend_data_q <= 32'h0;
      end else if (sync_start) begin
         sync_cnt_q  <= 4'(SYNC_CYCLES);
         sync_rd_q   <= rd_go;
         pend_idx_q  <= rd_go ? r_idx : w_idx;
         pend_data_q <= merged;
      end else if (busy) begin
         sync_cnt_q  <= sync_cnt_q - 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi4-lite write channels
   wire aw_full_d = aw_full_q ? ~wr_go : (i_s_awvalid & awrdy_q);
   wire w_full_d  = w_full_q ? ~wr_go : (i_s_wvalid & wrdy_q);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         aw_full_q <= 1'b0;
         awrdy_q   <= 1'b0;
         w_full_q  <= 1'b0;
         wrdy_q    <= 1'b0;
         awaddr_q  <= 8'h0;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= rtc_pkg::RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         awrdy_q   <= ~aw_full_d;
         w_full_q  <= w_full_d;
         wrdy_q    <= ~w_full_d;
         if (i_s_awvalid && awrdy_q)
            awaddr_q <= i_s_awaddr;
         if (i_s_wvalid && wrdy_q) begin
            wdata_q <= i_s_wdata;
            wstrb_q <= i_s_wstrb;
         end
         if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= w_map ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
         end else if (i_s_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // axi4-lite read channels, count reads wait for the handshake
   wire ar_full_d = ar_full_q ? ~rd_go : (i_s_arvalid & arrdy_q);

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ar_full_q <= 1'b0;
         arrdy_q   <= 1'b0;
         araddr_q  <= 8'h0;
         rd_wait_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= rtc_pkg::RESP_OKAY;
      end else begin
         ar_full_q <= ar_full_d;
         arrdy_q   <= ~ar_full_d;
         if (i_s_arvalid && arrdy_q)
            araddr_q <= i_s_araddr;
         if (rd_go && r_sync) begin
            rd_wait_q <= 1'b1;
         end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_val;
            rresp_q  <= r_map ? rtc_pkg::RESP_OKAY : rtc_pkg::RESP_SLVERR;
         end else if (sync_done && sync_rd_q) begin
            rd_wait_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= cnt_q;
            rresp_q   <= rtc_pkg::RESP_OKAY;
         end else if (i_s_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign o_s_awready = awrdy_q;
   assign o_s_wready  = wrdy_q;
   assign o_s_bvalid  = bvalid_q;
   assign o_s_bresp   = bresp_q;
   assign o_s_arready = arrdy_q;
   assign o_s_rvalid  = rvalid_q;
   assign o_s_rdata   = rdata_q;
   assign o_s_rresp   = rresp_q;
   assign o_irq       = irq_q;
   assign o_event     = evt_q;

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   a_busy_window: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      sync_start |=> busy [*3] ##1 !busy)
      else $error("sync busy window wrong length");
   a_sync_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      sync_done |=> flags_q[rtc_pkg::FLG_SYNC])
      else $error("sync done flag not set");
   a_stall_busy: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      busy && !sync_done |-> !sync_start)
      else $error("sync started while busy");
   a_wrap_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      tick && cnt_q == rtc_pkg::CNT_TOP && !ap_cnt && !sw_reset
      |=> cnt_q == 32'h0 && flags_q[rtc_pkg::FLG_WRAP])
      else $error("wrap did not clear counter or set flag");
   a_match_flag: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      tick && hit && !sw_reset |=> flags_q[rtc_pkg::FLG_MATCH0])
      else $error("match flag missing after tick");
   a_clear_match: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      tick && hit && mclr && !ap_cnt && !sw_reset
      |=> cnt_q == 32'h0 && flags_q[rtc_pkg::FLG_WRAP] && flags_q[rtc_pkg::FLG_MATCH0])
      else $error("clear on match failed");
   a_per_gate: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      evt_q.periodic != 8'h0 |-> $past(psel) != 4'h0)
      else $error("periodic event with zero prescaler setting");
   a_trim_insert: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      corr && !skip && !sw_reset |=> psc_q == $past(psc_q))
      else $error("insert correction moved prescaler");
   a_irq_level: assert property (@(posedge i_clock) disable iff (!i_rst_n)
      (flags_q & inten_q) != 8'h0 |=> o_irq)
      else $error("enabled flag did not raise request");
endmodule : rtc_core

// ===== design/rtc_pkg.sv
// shared constants and types for the real-time counter support block
package rtc_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // register indices, byte address is four times the index
   localparam logic [7:0]  IDX_CTRL      = 8'h00;
   localparam logic [7:0]  IDX_READ_REQUEST_STROBE      = 8'h02;
   localparam logic [7:0]  IDX_EVENT_OUTPUT_CONTROL    = 8'h04;
   localparam logic [7:0]  IDX_ENCLR     = 8'h06;
   localparam logic [7:0]  IDX_ENSET     = 8'h07;
   localparam logic [7:0]  IDX_FLAGS     = 8'h08;
   localparam logic [7:0]  IDX_STATUS    = 8'h0a;
   localparam logic [7:0]  IDX_DBG       = 8'h0b;
   localparam logic [7:0]  IDX_TRIM      = 8'h0c;
   localparam logic [7:0]  IDX_COUNT     = 8'h10;
   localparam logic [7:0]  IDX_MATCH0    = 8'h18;
   ////////////////////////////////////////////////////////////////////////////////
   // field positions and writable masks
   localparam int          CTRL_SOFT_RESET_BIT    = 0;
   localparam int          CTRL_EN       = 1;
   localparam int          CTRL_MODE_LO  = 2;
   localparam int          CTRL_MCLR     = 7;
   localparam int          CTRL_PSC_LO   = 8;
   localparam int          EV_MATCH0     = 8;
   localparam int          EV_WRAP       = 15;
   localparam int          FLG_MATCH0    = 0;
   localparam int          FLG_SYNC      = 6;
   localparam int          FLG_WRAP      = 7;
   localparam int          STAT_BUSY     = 7;
   localparam int          TRIM_SIGN     = 7;
   localparam int          DBG_RUN       = 0;
   localparam logic [15:0] CTRL_WMASK    = 16'h0f8f;
   localparam logic [15:0] READ_REQUEST_STROBE_WMASK    = 16'hc03f;
   localparam logic [15:0] EVENT_OUTPUT_CONTROL_WMASK  = 16'h81ff;
   localparam logic [7:0]  IRQ_MASK      = 8'hc1;
   localparam logic [7:0]  DBG_WMASK     = 8'h01;
   localparam logic [1:0]  MODE_COUNT32  = 2'h0;
   localparam logic [31:0] CNT_TOP       = 32'hffffffff;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   ////////////////////////////////////////////////////////////////////////////////
   // timing counts
   localparam int unsigned PSC_W         = 10;
   localparam int unsigned PER_BASE      = 2;
   localparam int unsigned WIN_CYCLES    = 4096;
   localparam int unsigned WIN_GROUP     = 240;
   localparam int unsigned SYNC_CYCLES   = 3;
   ////////////////////////////////////////////////////////////////////////////////
   // output event pulses
   typedef struct packed {
      logic [7:0] periodic;
      logic       wrap;
      logic       match0;
   } rtc_event_t;
endpackage : rtc_pkg

// ===== tb/rtc_far.sv
// far side model: tick source and event tally
`timescale 1ns/1ps
module rtc_far (
   input  wire logic                i_clock, // clock
   input  wire logic                i_rst_n, // reset
   input  wire logic                i_en,    // tally open
   input  wire rtc_pkg::rtc_event_t i_ev,    // device events
   output logic                     o_tick,  // tick every other cycle
   output logic [15:0]              o_c0,    // periodic 0 tally
   output logic [15:0]              o_c1,    // periodic 1 tally
   output logic [15:0]              o_cw     // wrap and match0 event tally
);
   // tick toggles, tallies count event pulses
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_tick <= 1'b0;
         o_c0   <= 16'h0;
         o_c1   <= 16'h0;
         o_cw   <= 16'h0;
      end else begin
         o_tick <= ~o_tick;
         o_c0   <= o_c0 + 16'(i_en & i_ev.periodic[0]);
         o_c1   <= o_c1 + 16'(i_en & i_ev.periodic[1]);
         o_cw   <= o_cw + 16'(i_ev.wrap) + 16'(i_ev.match0);
      end
   end
endmodule : rtc_far

// ===== tb/rtc_sync_periodic_trim_test.sv
// self-checking bench for the counter support block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch %s expected %h seen %h", n, e, g); end end
module rtc_sync_periodic_trim_test;
   logic        i_clock = '0, i_rst_n = '0, en = '0, awv = '0, wv = '0, br = '0, arv = '0;
   logic        rr = '0, tick, awr, wrd, bv, arr, rv, irq;
   logic [7:0]  awa = '0, ara = '0;
   logic [31:0] wd = '0, d, rdat;
   logic [15:0] c0, c1, b0, b1, cw;
   logic [1:0]  r, rres, wrs, bres;
   rtc_pkg::rtc_event_t ev;
   int          n_mismatch = 0, n_checks = 0;
   // clock
   always #5 i_clock = ~i_clock;
   rtc_core #(.WIN_CYCLES(16), .WIN_GROUP(4)) uut (.i_clock(i_clock), .i_rst_n(i_rst_n),
      .i_prescaler_tick(tick), .i_debug_halt(1'b0), .i_s_awaddr(awa), .i_s_awvalid(awv),
      .o_s_awready(awr), .i_s_wdata(wd), .i_s_wstrb(4'hf), .i_s_wvalid(wv), .o_s_wready(wrd),
      .o_s_bresp(bres), .o_s_bvalid(bv), .i_s_bready(br), .i_s_araddr(ara), .i_s_arvalid(arv),
      .o_s_arready(arr), .o_s_rdata(rdat), .o_s_rresp(rres), .o_s_rvalid(rv), .i_s_rready(rr),
      .o_irq(irq), .o_event(ev));
   rtc_far far (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_en(en), .i_ev(ev), .o_tick(tick),
      .o_c0(c0), .o_c1(c1), .o_cw(cw));
   // bus write, address and data released separately
   task automatic wr(input logic [7:0] ix, input logic [31:0] v);
      logic a;
      logic w;
      @(posedge i_clock);
      a = 1'b1;
      w = 1'b1;
      awa <= {ix[5:0], 2'h0};
      wd <= v;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      while (a | w) begin
         @(posedge i_clock);
         if (awr === 1'b1) awv <= 1'b0;
         if (wrd === 1'b1) wv <= 1'b0;
         a = a & (awr !== 1'b1);
         w = w & (wrd !== 1'b1);
      end
      do @(posedge i_clock); while (bv !== 1'b1);
      br <= 1'b0;
      wrs = bres;
   endtask : wr
   // bus read into d and r
   task automatic rd(input logic [7:0] ix);
      @(posedge i_clock);
      ara <= {ix[5:0], 2'h0};
      arv <= 1'b1;
      rr <= 1'b1;
      do @(posedge i_clock); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge i_clock); while (rv !== 1'b1);
      rr <= 1'b0;
      d = rdat;
      r = rres;
   endtask : rd
   // tally events over 256 cycles
   task automatic tally;
      @(posedge i_clock);
      b0 = c0;
      b1 = c1;
      en <= 1'b1;
      repeat (256) @(posedge i_clock);
      en <= 1'b0;
      @(posedge i_clock);
   endtask : tally
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : report_and_stop
   // main sequence
   initial begin
      repeat (5) @(posedge i_clock);
      i_rst_n <= 1'b1;
      rd(8'h3f);
      `CHK("unmapped", rtc_pkg::RESP_SLVERR, r)
      wr(rtc_pkg::IDX_ENSET, 32'hc1);
      wr(rtc_pkg::IDX_CTRL, 32'h0102);
      rd(rtc_pkg::IDX_ENSET);
      `CHK("enable", 8'hc1, d[7:0])
      rd(rtc_pkg::IDX_FLAGS);
      `CHK("sync_done", 8'h40, d[7:0] & 8'h40)
      `CHK("irq_on", 1'b1, irq)
      wr(rtc_pkg::IDX_FLAGS, 32'h0);
      rd(rtc_pkg::IDX_FLAGS);
      `CHK("flag_kept", 8'h40, d[7:0] & 8'h40)
      wr(rtc_pkg::IDX_FLAGS, 32'hc1);
      wr(rtc_pkg::IDX_ENCLR, 32'hc1);
      rd(rtc_pkg::IDX_FLAGS);
      `CHK("flag_clr", 8'h0, d[7:0] & 8'h40)
      `CHK("irq_off", 1'b0, irq)
      wr(rtc_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h8100);
      // count read issued with a count write, so it stalls behind the handshake
      fork
         wr(rtc_pkg::IDX_COUNT, 32'hfffffff0);
         rd(rtc_pkg::IDX_COUNT);
      join
      `CHK("stall_rd", 28'hfffffff, d[31:4])
      wr(rtc_pkg::IDX_MATCH0, 32'h10);
      rd(rtc_pkg::IDX_MATCH0);
      `CHK("match0", 32'h10, d)
      repeat (150) @(posedge i_clock);
      rd(rtc_pkg::IDX_FLAGS);
      `CHK("wrap_match", 8'h81, d[7:0] & 8'h81)
      `CHK("ev_wm", 16'h2, cw)
      rd(rtc_pkg::IDX_COUNT);
      `CHK("count", 24'h0, d[31:8])
      wr(rtc_pkg::IDX_EVENT_OUTPUT_CONTROL, 32'h3);
      tally();
      `CHK("per0", 16'h10, c0 - b0)
      `CHK("per1", 16'h8, c1 - b1)
      wr(rtc_pkg::IDX_CTRL, 32'h0202);
      wr(rtc_pkg::IDX_TRIM, 32'h04);
      repeat (4) @(posedge i_clock);
      tally();
      `CHK("trim_ins", 16'hf, c0 - b0)
      wr(rtc_pkg::IDX_TRIM, 32'h84);
      repeat (4) @(posedge i_clock);
      tally();
      `CHK("trim_skip", 16'h11, c0 - b0)
      wr(rtc_pkg::IDX_CTRL, 32'h0002);
      repeat (4) @(posedge i_clock);
      tally();
      `CHK("per_off", 16'h0, c0 - b0)
      wr(rtc_pkg::IDX_CTRL, 32'h0);
      wr(rtc_pkg::IDX_CTRL, 32'h1);
      repeat (4) @(posedge i_clock);
      rd(rtc_pkg::IDX_EVENT_OUTPUT_CONTROL);
      `CHK("soft_reset_bit", 32'h0, d)
      wr(rtc_pkg::IDX_CTRL, 32'h4);
      rd(rtc_pkg::IDX_COUNT);
      `CHK("mode1", rtc_pkg::RESP_SLVERR, r)
      wr(rtc_pkg::IDX_MATCH0, 32'h0);
      `CHK("mode1_w", rtc_pkg::RESP_SLVERR, wrs)
      report_and_stop();
   end
   // watchdog
   initial begin
      repeat (20000) @(posedge i_clock);
      n_mismatch++;
      report_and_stop();
   end
endmodule : rtc_sync_periodic_trim_test
